// ==== dsa_params.svh ====
// constants for the data space access unit: address map, field positions, sizes
// assumes inclusion by every design file of the block before its code
`ifndef DSA_PARAMS_SVH
`define DSA_PARAMS_SVH

`define DSA_ADDR_W        16
`define DSA_DATA_W        16
`define DSA_PAGE_W        8
`define DSA_WORD_ADDR_W   15
`define DSA_SFR_LAST      16'h0FFF
`define DSA_NEAR_LAST     16'h1FFF
`define DSA_NEAR_FIELD_W  13
`define DSA_RAM_BYTES     32'hC000
`define DSA_SFR_BYTES     32'h1000
`define DSA_IMPL_LAST     16'hCFFF
`define DSA_BYTE_STEP     16'h0001
`define DSA_WORD_STEP     16'h0002
`define DSA_LANE_BIT      0
`define DSA_PAGE_RST      8'h01

`endif

// ==== dsa_pkg.sv ====
// types shared by the data space access unit
// assumes dsa_params.svh defines the widths
`default_nettype none
`include "dsa_params.svh"
package dsa_pkg;
  typedef enum logic [1:0] {
    DSA_OP_MOVE  = 2'b00,
    DSA_OP_SEXT  = 2'b01,
    DSA_OP_ZEXT  = 2'b10
  } dsa_op_type;
endpackage
`default_nettype wire

// ==== dsa_agu.sv ====
// address generation unit: forms effective address, page extension and post-increment
// assumes the core presents a pointer and operand size in the same clock
`default_nettype none
`include "dsa_params.svh"
module dsa_agu
  import dsa_pkg::*;
(
  input  wire logic [`DSA_ADDR_W-1:0] i_pointer,
  input  wire logic [`DSA_PAGE_W-1:0] i_page,
  input  wire logic                   i_byte_op,
  output logic      [`DSA_ADDR_W-1:0] o_effective_address,
  output logic      [`DSA_PAGE_W+`DSA_ADDR_W-1:0] o_extended_address,
  output logic      [`DSA_ADDR_W-1:0] o_next_pointer,
  output logic                        o_misaligned
);
  always_comb begin
    o_effective_address = i_pointer;
    o_extended_address  = {i_page, i_pointer};
    o_next_pointer      = i_pointer + (i_byte_op ? `DSA_BYTE_STEP : `DSA_WORD_STEP);
    o_misaligned        = !i_byte_op && i_pointer[`DSA_LANE_BIT];
  end
endmodule
`default_nettype wire

// ==== dsa_data_space_access.sv ====
// data space access unit: read and write paths between core and byte-lane memory array
// assumes an array that returns read data in the cycle o_mem_rd is high, driven from the o_mem_* ports
`default_nettype none
`include "dsa_params.svh"
// Behaviour
// - effective addresses are 16-bit byte addresses, 64 Kbytes base space
// - reads and writes use separate address generation units
// - page registers extend read and write addresses to 16 Mbytes
// - implemented memory: 4 Kbytes registers plus up to 48 Kbytes RAM
// - reads outside implemented memory return zero
// - low byte at even address, high byte at odd address
// - post-increment pointer by one for bytes, two for words
// - byte read fetches whole word, selects by bit 0, returns low byte
// - shared word address, separate lane strobes for byte writes
// - word accesses must be even; misaligned ones raise address error trap
// - misaligned read lets instruction complete, then trap
// - misaligned write executes but suppresses memory write, then trap
// - byte loads update low byte of working register only
// - signed widen and clear upper byte operations on working register
// - addresses 0x0000 to 0x0FFF hold special function registers
// - unused special function register addresses read as zero
// - addresses 0x0000 to 0x1FFF reachable by 13-bit direct field
module dsa_data_space_access
  import dsa_pkg::*;
#(
  parameter logic [`DSA_ADDR_W-1:0] IMPL_LAST = `DSA_IMPL_LAST
)(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_nrst,
  // read request from execution
  input  wire logic                   i_rd_req,
  input  wire logic                   i_rd_byte,
  input  wire logic                   i_rd_direct,
  input  wire logic [`DSA_NEAR_FIELD_W-1:0] i_rd_direct_addr,
  input  wire logic [`DSA_ADDR_W-1:0] i_rd_pointer,
  input  wire logic [`DSA_DATA_W-1:0] i_rd_dest_old,
  input  wire dsa_op_type             i_rd_op,
  // write request from execution
  input  wire logic                   i_wr_req,
  input  wire logic                   i_wr_byte,
  input  wire logic [`DSA_ADDR_W-1:0] i_wr_pointer,
  input  wire logic [`DSA_DATA_W-1:0] i_wr_data,
  // page registers written by the core
  input  wire logic                   i_rd_page_we,
  input  wire logic                   i_wr_page_we,
  input  wire logic [`DSA_PAGE_W-1:0] i_page_data,
  // memory array, word addressed, lane strobes
  input  wire logic [`DSA_DATA_W-1:0] i_mem_rdata,
  input  wire logic                   i_sfr_hit,
  output logic                        o_mem_rd,
  output logic      [`DSA_PAGE_W+`DSA_WORD_ADDR_W-1:0] o_mem_rd_addr,
  output logic                        o_mem_wr,
  output logic      [`DSA_PAGE_W+`DSA_WORD_ADDR_W-1:0] o_mem_wr_addr,
  output logic      [1:0]             o_mem_wr_lane,
  output logic      [`DSA_DATA_W-1:0] o_mem_wdata,
  // results to execution
  output logic                        o_rd_valid,
  output logic      [`DSA_DATA_W-1:0] o_rd_data,
  output logic      [`DSA_ADDR_W-1:0] o_rd_pointer_next,
  output logic      [`DSA_ADDR_W-1:0] o_wr_pointer_next,
  output logic                        o_near,
  output logic      [`DSA_PAGE_W-1:0] o_data_read_page_register,
  output logic      [`DSA_PAGE_W-1:0] o_data_write_page_register,
  // exception logic
  output logic                        o_addr_trap,
  output logic                        o_addr_trap_write
);
  typedef struct packed {
    logic [`DSA_PAGE_W-1:0]                    rd_page;
    logic [`DSA_PAGE_W-1:0]                    wr_page;
    logic                                      mem_rd;
    logic [`DSA_PAGE_W+`DSA_WORD_ADDR_W-1:0]   mem_rd_addr;
    logic                                      mem_wr;
    logic [`DSA_PAGE_W+`DSA_WORD_ADDR_W-1:0]   mem_wr_addr;
    logic [1:0]                                mem_wr_lane;
    logic [`DSA_DATA_W-1:0]                    mem_wdata;
    logic                                      pend;
    logic                                      pend_byte;
    logic                                      pend_lane;
    logic                                      pend_zero;
    logic [`DSA_DATA_W-1:0]                    pend_old;
    dsa_op_type                                pend_op;
    logic                                      rd_valid;
    logic [`DSA_DATA_W-1:0]                    rd_data;
    logic [`DSA_ADDR_W-1:0]                    rd_ptr_next;
    logic [`DSA_ADDR_W-1:0]                    wr_ptr_next;
    logic                                      near;
    logic                                      trap_rd_pend;
    logic                                      trap;
    logic                                      trap_write;
  } dsa_state_type;

  dsa_state_type state;
  dsa_state_type next_state;

  logic [`DSA_ADDR_W-1:0]                  rd_source;
  logic [`DSA_ADDR_W-1:0]                  rd_ea;
  logic [`DSA_PAGE_W+`DSA_ADDR_W-1:0]      rd_ext;
  logic [`DSA_ADDR_W-1:0]                  rd_ptr_inc;
  logic                                    rd_misaligned;
  logic [`DSA_ADDR_W-1:0]                  wr_ea;
  logic [`DSA_PAGE_W+`DSA_ADDR_W-1:0]      wr_ext;
  logic [`DSA_ADDR_W-1:0]                  wr_ptr_inc;
  logic                                    wr_misaligned;
  logic [7:0]                              sel_byte;
  logic [`DSA_DATA_W-1:0]                  loaded;

  // direct field reaches only the near region
  assign rd_source = i_rd_direct ? {3'h0, i_rd_direct_addr} : i_rd_pointer;

  dsa_agu u_rd_agu (
    .i_pointer           (rd_source),
    .i_page              (state.rd_page),
    .i_byte_op           (i_rd_byte),
    .o_effective_address (rd_ea),
    .o_extended_address  (rd_ext),
    .o_next_pointer      (rd_ptr_inc),
    .o_misaligned        (rd_misaligned)
  );

  dsa_agu u_wr_agu (
    .i_pointer           (i_wr_pointer),
    .i_page              (state.wr_page),
    .i_byte_op           (i_wr_byte),
    .o_effective_address (wr_ea),
    .o_extended_address  (wr_ext),
    .o_next_pointer      (wr_ptr_inc),
    .o_misaligned        (wr_misaligned)
  );

  // region decode of each effective address
  logic                                    rd_impl;
  logic                                    rd_near;
  logic                                    wr_impl;

  assign rd_impl = (rd_ea <= IMPL_LAST);
  assign rd_near = (rd_ea <= `DSA_NEAR_LAST);
  assign wr_impl = (wr_ea <= IMPL_LAST);

  // returning read: zero outside memory or at an unused register word
  logic [`DSA_WORD_ADDR_W-1:0]             ret_word_addr;
  logic                                    ret_in_sfr;
  logic                                    ret_zero;
  logic [`DSA_DATA_W-1:0]                  ret_word;

  assign ret_word_addr = state.mem_rd_addr[`DSA_WORD_ADDR_W-1:0];
  assign ret_in_sfr    = (ret_word_addr <= `DSA_WORD_ADDR_W'(`DSA_SFR_LAST >> 1));
  assign ret_zero      = state.pend_zero || (ret_in_sfr && !i_sfr_hit);
  assign ret_word      = ret_zero ? 16'h0000 : i_mem_rdata;

  // per-lane logic: lane 0 is the even byte, lane 1 the odd byte
  logic [1:0]                              wr_lane_hit;
  logic [1:0]                              wr_lane_we;
  logic [`DSA_DATA_W-1:0]                  wr_lane_data;
  logic [1:0]                              ret_lane_hit;
  logic [`DSA_DATA_W-1:0]                  ret_lane_data;

  genvar lane;
  generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
      assign wr_lane_hit[lane]          = (wr_ea[`DSA_LANE_BIT] == (lane == 1));
      // a word strobes both lanes, a byte only its own and copies its data there
      assign wr_lane_we[lane]           = !i_wr_byte || wr_lane_hit[lane];
      assign wr_lane_data[8*lane +: 8]  = i_wr_byte ? i_wr_data[7:0] : i_wr_data[8*lane +: 8];
      assign ret_lane_hit[lane]         = (state.pend_lane == (lane == 1));
      assign ret_lane_data[8*lane +: 8] = ret_lane_hit[lane] ? ret_word[8*lane +: 8] : 8'h00;
    end
  endgenerate

  // trap sources: a read fault waits for its data, a write fault is raised at once
  logic                                    trap_rd;
  logic                                    trap_wr;

  assign trap_rd = state.pend && state.trap_rd_pend;
  assign trap_wr = i_wr_req && wr_misaligned;

  always_comb begin
    next_state = state;
    sel_byte = 8'h00;
    loaded = 16'h0000;
    next_state.mem_rd = 1'b0;
    next_state.mem_wr = 1'b0;
    next_state.mem_wr_lane = 2'b00;
    next_state.rd_valid = 1'b0;
    next_state.trap = 1'b0;
    next_state.trap_write = 1'b0;
    next_state.pend = 1'b0;
    next_state.trap_rd_pend = 1'b0;

    if (i_rd_page_we) begin
      next_state.rd_page = i_page_data;
    end
    if (i_wr_page_we) begin
      next_state.wr_page = i_page_data;
    end

    // read issue: whole word fetched, lane kept for the return
    if (i_rd_req) begin
      next_state.mem_rd = 1'b1;
      next_state.mem_rd_addr = {rd_ext[`DSA_PAGE_W+`DSA_ADDR_W-1:`DSA_ADDR_W],
                                rd_ext[`DSA_ADDR_W-1:1]};
      next_state.pend = 1'b1;
      next_state.pend_byte = i_rd_byte;
      next_state.pend_lane = rd_ea[`DSA_LANE_BIT];
      next_state.pend_zero = !rd_impl;
      next_state.pend_old = i_rd_dest_old;
      next_state.pend_op = i_rd_op;
      next_state.rd_ptr_next = rd_ptr_inc;
      next_state.near = rd_near;
      next_state.trap_rd_pend = rd_misaligned;
    end

    // read return: data and any read trap are raised in the same cycle
    if (state.pend) begin
      loaded = ret_word;
      sel_byte = ret_lane_data[15:8] | ret_lane_data[7:0];
      if (state.pend_byte) begin
        loaded = {state.pend_old[15:8], sel_byte};
      end
      unique case (state.pend_op)
        DSA_OP_MOVE: next_state.rd_data = loaded;
        DSA_OP_SEXT: next_state.rd_data = {{8{loaded[7]}}, loaded[7:0]};
        DSA_OP_ZEXT: next_state.rd_data = {8'h00, loaded[7:0]};
        default:     next_state.rd_data = loaded;
      endcase
      next_state.rd_valid = 1'b1;
      if (trap_rd) begin
        next_state.trap = 1'b1;
        next_state.trap_write = 1'b0;
      end
    end

    // write: strobe both lanes for a word, only the matching lane for a byte, none when misaligned or outside implemented memory
    if (i_wr_req) begin
      next_state.wr_ptr_next = wr_ptr_inc;
      next_state.mem_wr_addr = {wr_ext[`DSA_PAGE_W+`DSA_ADDR_W-1:`DSA_ADDR_W],
                                wr_ext[`DSA_ADDR_W-1:1]};
      if (trap_wr) begin
        next_state.trap = 1'b1;
        next_state.trap_write = 1'b1;
      end else if (wr_impl) begin
        next_state.mem_wr = 1'b1;
        next_state.mem_wr_lane = wr_lane_we;
        next_state.mem_wdata = wr_lane_data;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= '{rd_page: `DSA_PAGE_RST, wr_page: `DSA_PAGE_RST, pend_op: DSA_OP_MOVE, default: '0};
    end else begin
      state <= next_state;
    end
  end

  assign o_mem_rd                   = state.mem_rd;
  assign o_mem_rd_addr              = state.mem_rd_addr;
  assign o_mem_wr                   = state.mem_wr;
  assign o_mem_wr_addr              = state.mem_wr_addr;
  assign o_mem_wr_lane              = state.mem_wr_lane;
  assign o_mem_wdata                = state.mem_wdata;
  assign o_rd_valid                 = state.rd_valid;
  assign o_rd_data                  = state.rd_data;
  assign o_rd_pointer_next          = state.rd_ptr_next;
  assign o_wr_pointer_next          = state.wr_ptr_next;
  assign o_near                     = state.near;
  assign o_data_read_page_register  = state.rd_page;
  assign o_data_write_page_register = state.wr_page;
  assign o_addr_trap                = state.trap;
  assign o_addr_trap_write          = state.trap_write;
endmodule
`default_nettype wire

// ==== dsa_mem_model.sv ====
// behavioural byte-lane memory array facing the access unit
// assumes read data is wanted while o_mem_rd is high, writes land at the next edge
`default_nettype none
module dsa_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rd,
  input  wire logic [22:0] i_rd_addr,
  input  wire logic        i_wr,
  input  wire logic [22:0] i_wr_addr,
  input  wire logic [1:0]  i_wr_lane,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata,
  output logic             o_sfr_hit
);
  logic [15:0] mem [0:131071];
  logic [15:0] last_data = 16'h0000;
  logic        last_hit  = 1'b0;
  logic [15:0] cur;
  // unwritten words hold an address pattern, never zero; pages alias modulo four
  initial begin
    for (int k = 0; k < 131072; k++) begin
      mem[k] = {k[7:0] ^ 8'h5A, k[7:0]};
    end
  end
  function automatic logic [15:0] peek(input logic [22:0] a);
    return mem[a[16:0]];
  endfunction
  // an idle array shows the inverse of its last value
  assign o_rdata   = i_rd ? peek(i_rd_addr) : ~last_data;
  assign o_sfr_hit = i_rd ? (i_rd_addr[14:0] < 15'h0100) : ~last_hit;
  always @(posedge i_core_clk) begin
    last_data <= o_rdata;
    last_hit  <= o_sfr_hit;
    cur = peek(i_wr_addr);
    if (i_wr) begin
      mem[i_wr_addr[16:0]] = {i_wr_lane[1] ? i_wdata[15:8] : cur[15:8],
                              i_wr_lane[0] ? i_wdata[7:0] : cur[7:0]};
    end
  end
endmodule
`default_nettype wire

// ==== dsa_data_space_access_chk.sv ====
// assertions on the data space access unit ports
// assumes one clock and the active-low asynchronous reset
`default_nettype none
`include "dsa_params.svh"
module dsa_chk #(
  parameter logic [15:0] IMPL_LAST = `DSA_IMPL_LAST
)(
  input wire logic        i_core_clk, i_nrst, i_rd_req, i_rd_byte, i_rd_direct, i_wr_req, i_wr_byte,
  input wire logic [12:0] i_rd_direct_addr,
  input wire logic [15:0] i_rd_pointer, i_wr_pointer, o_rd_pointer_next,
  input wire logic        o_mem_rd, o_mem_wr, o_rd_valid, o_near, o_addr_trap, o_addr_trap_write,
  input wire logic [22:0] o_mem_wr_addr,
  input wire logic [1:0]  o_mem_wr_lane,
  input wire logic [7:0]  o_data_write_page_register
);
  wire logic [15:0] rd_ea  = i_rd_direct ? {3'h0, i_rd_direct_addr} : i_rd_pointer;
  wire logic        rd_mis = i_rd_req & ~i_rd_byte & rd_ea[0];
  wire logic        wr_mis = i_wr_req & ~i_wr_byte & i_wr_pointer[0];
  wire logic        wr_ok  = i_wr_req & ~wr_mis & (i_wr_pointer <= IMPL_LAST);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_rd_flow;
    o_mem_rd ##1 o_rd_valid;
  endsequence
  sequence s_rd_fault;
    rd_mis ##1 !wr_mis;
  endsequence
  a_rd_flow: assert property (i_rd_req |=> s_rd_flow)
    else $error("read did not finish in two cycles");
  a_rd_trap: assert property (s_rd_fault |=> o_addr_trap && !o_addr_trap_write)
    else $error("misaligned read trap missing");
  a_wr_trap: assert property (wr_mis |=> o_addr_trap && o_addr_trap_write && !o_mem_wr)
    else $error("misaligned write not trapped or not dropped");
  a_trap_cause: assert property (o_addr_trap |-> $past(wr_mis) || $past(rd_mis, 2))
    else $error("trap without misaligned word access");
  a_byte_lane: assert property (wr_ok && i_wr_byte |=> o_mem_wr && o_mem_wr_lane == ($past(i_wr_pointer[0]) ? 2'h2 : 2'h1))
    else $error("byte write lane wrong");
  a_wr_addr: assert property (wr_ok |=>
    o_mem_wr_addr == {$past(o_data_write_page_register), $past(i_wr_pointer[15:1])})
    else $error("write word address wrong");
  a_wr_drop: assert property (i_wr_req && i_wr_pointer > IMPL_LAST |=> !o_mem_wr)
    else $error("write outside memory reached array");
  a_ptr_step: assert property (i_rd_req && !i_rd_direct |=>
    o_rd_pointer_next == $past(i_rd_pointer) + ($past(i_rd_byte) ? 16'h0001 : 16'h0002))
    else $error("pointer step wrong");
  a_near_flag: assert property (i_rd_req |=> o_near == ($past(rd_ea) <= 16'h1FFF))
    else $error("near flag wrong");
endmodule
bind dsa_data_space_access dsa_chk #(.IMPL_LAST(IMPL_LAST)) dsa_chk_i (.i_core_clk, .i_nrst, .i_rd_req, .i_rd_byte,
  .i_rd_direct, .i_wr_req, .i_wr_byte, .i_rd_direct_addr, .i_rd_pointer, .i_wr_pointer, .o_rd_pointer_next, .o_mem_rd,
  .o_mem_wr, .o_rd_valid, .o_near, .o_addr_trap, .o_addr_trap_write, .o_mem_wr_addr, .o_mem_wr_lane,
  .o_data_write_page_register);
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench: table of write/read pairs, then pages, faults, near and reset
// assumes the memory model answers reads in the cycle o_mem_rd is high
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dsa_pkg::*;
  typedef struct {logic wb; logic [15:0] a; logic [15:0] d; logic rb; dsa_op_type op; logic [15:0] old, exp;} dsa_row_type;
  logic i_core_clk = 1'b0, i_nrst = 1'b0, i_rd_req = 1'b0, i_rd_byte = 1'b0, i_rd_direct = 1'b0;
  logic i_wr_req = 1'b0, i_wr_byte = 1'b0, i_rd_page_we = 1'b0, i_wr_page_we = 1'b0, i_sfr_hit;
  logic [12:0] i_rd_direct_addr = 13'h0000;
  logic [15:0] i_rd_pointer = 16'h0000, i_rd_dest_old = 16'h0000, i_wr_pointer = 16'h0000, i_wr_data = 16'h0000;
  logic [15:0] i_mem_rdata, o_mem_wdata, o_rd_data, o_rd_pointer_next, o_wr_pointer_next;
  logic [7:0]  i_page_data = 8'h00, o_data_read_page_register, o_data_write_page_register;
  logic [22:0] o_mem_rd_addr, o_mem_wr_addr;
  logic [1:0]  o_mem_wr_lane, wl;
  logic        o_mem_rd, o_mem_wr, o_rd_valid, o_near, o_addr_trap, o_addr_trap_write, got, tr, trw, mw;
  dsa_op_type  i_rd_op = DSA_OP_MOVE;
  int errors = 0, compares = 0;
  dsa_row_type rows [10] = '{
    '{0, 16'h1000, 16'h1234, 0, DSA_OP_MOVE, 16'h0000, 16'h1234}, '{1, 16'h1003, 16'h00AB, 1, DSA_OP_MOVE, 16'h5555, 16'h55AB},
    '{1, 16'h1004, 16'h0080, 1, DSA_OP_SEXT, 16'h1234, 16'hFF80}, '{1, 16'h1006, 16'h007F, 1, DSA_OP_ZEXT, 16'hAAAA, 16'h007F},
    '{0, 16'hCFFE, 16'hBEEF, 0, DSA_OP_MOVE, 16'h0000, 16'hBEEF}, '{0, 16'hD000, 16'h4321, 0, DSA_OP_MOVE, 16'h0000, 16'h0000},
    '{0, 16'h0800, 16'h1111, 0, DSA_OP_MOVE, 16'h0000, 16'h0000}, '{0, 16'h0100, 16'h2222, 0, DSA_OP_MOVE, 16'h0000, 16'h2222},
    '{1, 16'h1008, 16'h00CD, 1, DSA_OP_MOVE, 16'h0000, 16'h00CD}, '{1, 16'hD001, 16'h0055, 1, DSA_OP_MOVE, 16'h9900, 16'h9900}};
  always #5 i_core_clk = ~i_core_clk;
  dsa_data_space_access #(.IMPL_LAST(16'hCFFF)) dsa_data_space_access_i (.i_core_clk, .i_nrst, .i_rd_req, .i_rd_byte,
    .i_rd_direct, .i_rd_direct_addr, .i_rd_pointer, .i_rd_dest_old, .i_rd_op, .i_wr_req, .i_wr_byte, .i_wr_pointer,
    .i_wr_data, .i_rd_page_we, .i_wr_page_we, .i_page_data, .i_mem_rdata, .i_sfr_hit, .o_mem_rd, .o_mem_rd_addr,
    .o_mem_wr, .o_mem_wr_addr, .o_mem_wr_lane, .o_mem_wdata, .o_rd_valid, .o_rd_data, .o_rd_pointer_next,
    .o_wr_pointer_next, .o_near, .o_data_read_page_register, .o_data_write_page_register, .o_addr_trap, .o_addr_trap_write);
  dsa_mem_model dsa_mem_model_i (.i_core_clk, .i_rd(o_mem_rd), .i_rd_addr(o_mem_rd_addr), .i_wr(o_mem_wr),
    .i_wr_addr(o_mem_wr_addr), .i_wr_lane(o_mem_wr_lane), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata), .o_sfr_hit(i_sfr_hit));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // expected {trap, trap kind, write strobe, lanes} of a well-formed write
  function automatic logic [15:0] strobe(input logic b, input logic [15:0] a);
    if (a > 16'hCFFF) return 16'h0000;
    return b ? (a[0] ? 16'h0006 : 16'h0005) : 16'h0007;
  endfunction
  task automatic conclude();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // word accesses from the bench are even unless a fault is meant
  task automatic rd(input logic b, input logic dir, input logic [15:0] a, input dsa_op_type op, input logic [15:0] old);
    @(posedge i_core_clk);
    {i_rd_req, i_rd_byte, i_rd_direct} <= {1'b1, b, dir};
    // a direct read gets a misleading pointer so the source select is exercised
    i_rd_pointer <= dir ? ~a : a;
    i_rd_direct_addr <= a[12:0];
    i_rd_op <= op;
    i_rd_dest_old <= old;
    @(posedge i_core_clk);
    i_rd_req <= 1'b0;
    {got, tr, trw} = 3'b000;
    for (int n = 0; n < 4 && !got; n++) begin
      @(posedge i_core_clk);
      #1;
      got = (o_rd_valid === 1'b1);
      tr |= o_addr_trap;
      trw |= o_addr_trap_write;
    end
    chk("rd_valid", 16'h0001, {15'h0000, got});
  endtask
  task automatic wr(input logic b, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    {i_wr_req, i_wr_byte, i_wr_pointer, i_wr_data} <= {1'b1, b, a, d};
    @(posedge i_core_clk);
    i_wr_req <= 1'b0;
    #1;
    {tr, trw, mw, wl} = {o_addr_trap, o_addr_trap_write, o_mem_wr, o_mem_wr_lane};
  endtask
  task automatic pg(input logic r, input logic w, input logic [7:0] d);
    @(posedge i_core_clk);
    {i_rd_page_we, i_wr_page_we, i_page_data} <= {r, w, d};
    @(posedge i_core_clk);
    {i_rd_page_we, i_wr_page_we} <= 2'b00;
  endtask
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    #1;
    chk("pages", 16'h0101, {o_data_read_page_register, o_data_write_page_register});
    foreach (rows[i]) begin
      wr(rows[i].wb, rows[i].a, rows[i].d);
      chk("wr_ptr", rows[i].a + (rows[i].wb ? 16'h0001 : 16'h0002), o_wr_pointer_next);
      chk("wr_strobe", strobe(rows[i].wb, rows[i].a), {11'h000, tr, trw, mw, wl});
      rd(rows[i].rb, 1'b0, rows[i].a, rows[i].op, rows[i].old);
      chk("rd_data", rows[i].exp, o_rd_data);
      chk("rd_ptr", rows[i].a + (rows[i].rb ? 16'h0001 : 16'h0002), o_rd_pointer_next);
      chk("no_trap", 16'h0000, {14'h0000, tr, trw});
    end
    pg(1'b0, 1'b1, 8'h02);
    wr(1'b0, 16'h1000, 16'h7777);
    rd(1'b0, 1'b0, 16'h1000, DSA_OP_MOVE, 16'h0000);
    chk("page_split", 16'h1234, o_rd_data);
    pg(1'b1, 1'b0, 8'h02);
    rd(1'b0, 1'b0, 16'h1000, DSA_OP_MOVE, 16'h0000);
    chk("page_hit", 16'h7777, o_rd_data);
    pg(1'b1, 1'b1, 8'h01);
    rd(1'b0, 1'b0, 16'h1001, DSA_OP_MOVE, 16'h0000);
    chk("rd_fault", 16'h0002, {14'h0000, tr, trw});
    wr(1'b0, 16'h1001, 16'h9999);
    chk("wr_fault", 16'h0006, {13'h0000, tr, trw, mw});
    rd(1'b0, 1'b0, 16'h1000, DSA_OP_MOVE, 16'h0000);
    chk("wr_kept", 16'h1234, o_rd_data);
    rd(1'b0, 1'b1, 16'h0100, DSA_OP_MOVE, 16'h0000);
    chk("direct", 16'h2222, o_rd_data);
    rd(1'b0, 1'b1, 16'h1FFE, DSA_OP_MOVE, 16'h0000);
    chk("near_in", 16'h0001, {15'h0000, o_near});
    rd(1'b0, 1'b0, 16'h2000, DSA_OP_MOVE, 16'h0000);
    chk("near_out", 16'h0000, {15'h0000, o_near});
    pg(1'b1, 1'b1, 8'h33);
    #1;
    chk("pages_set", 16'h3333, {o_data_read_page_register, o_data_write_page_register});
    @(posedge i_core_clk);
    i_nrst <= 1'b0;
    @(posedge i_core_clk);
    i_nrst <= 1'b1;
    #1;
    chk("pages_rst", 16'h0101, {o_data_read_page_register, o_data_write_page_register});
    rd(1'b0, 1'b0, 16'h1000, DSA_OP_MOVE, 16'h0000);
    chk("rd_after_rst", 16'h1234, o_rd_data);
    conclude();
  end
  initial begin
    #20000;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
